//--- core/nvc_pkg.sv
// Purpose: Shared constants for the memory command controller
// Assumes: 32-bit AHB-Lite word per register, byte address = index * 4
// Notes:   Register indexes below keep the printed offsets
package nvc_pkg;

  // Register indexes; byte address is index shifted left by two
  localparam logic [5:0] IDX_COMMAND  = 6'h00;
  localparam logic [5:0] IDX_PROTECT  = 6'h01;
  localparam logic [5:0] IDX_STATUS   = 6'h02;
  localparam logic [5:0] IDX_IRQ_EN   = 6'h03;
  localparam logic [5:0] IDX_IRQ_FLAG = 6'h04;
  localparam logic [5:0] IDX_VALUE    = 6'h06;
  localparam logic [5:0] IDX_LOCATION = 6'h08;
  localparam logic [5:0] IDX_KEY      = 6'h0A;

  // Field positions
  localparam int CMD_W          = 3;
  localparam int BIT_APP_GUARD  = 0;
  localparam int BIT_BOOT_LOCK  = 1;
  localparam int BIT_FL_ACTIVE  = 0;
  localparam int BIT_EE_ACTIVE  = 1;
  localparam int BIT_FAULT      = 2;
  localparam int BIT_EE_IDLE    = 0;

  // Command codes
  localparam logic [2:0] CMD_NONE      = 3'h0;
  localparam logic [2:0] CMD_PAGE_PROG = 3'h1;
  localparam logic [2:0] CMD_PAGE_WIPE = 3'h2;
  localparam logic [2:0] CMD_WIPE_PROG = 3'h3;
  localparam logic [2:0] CMD_BUF_RESET = 3'h4;
  localparam logic [2:0] CMD_FULL_WIPE = 3'h5;
  localparam logic [2:0] CMD_EE_WIPE   = 3'h6;
  localparam logic [2:0] CMD_CFG_PROG  = 3'h7;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Key value unlocking the command register
  localparam logic [7:0] SELF_PROGRAM_KEY = 8'h9D;

  // Timing counts in CPU cycles (one instruction taken as one cycle)
  localparam logic [2:0] KEY_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] BUF_RESET_CYCLES  = 3'h7;

endpackage

//--- core/nvc_ctrl.sv
// Purpose: Command, protection and status control for flash and EEPROM
// Assumes: AHB-Lite word accesses only; memory arrays report done pulses
// Notes:   Reads insert one wait state, writes none
// Functional notes
// R1 - Three-bit command field decoded to eight actions
// R2 - Software writes key before command, within four
// R3 - Chip erase spares EEPROM when preserve fuse set
// R4 - Fuse write accepted only from debug port
// R5 - Locked boot section reads and fetches zero
// R6 - Boot lock written only from boot; reset clears
// R7 - Boot lock acts after leaving boot section
// R8 - Application guard blocks writes; set-only until reset
// R9 - Write error flags failed last operation
// R10 - EEPROM active bit while EEPROM runs command
// R11 - Flash active bit while flash runs command
// R12 - EEPROM idle interrupt level, enable bit zero
// R13 - Software enables interrupt late, disables in handler
// R14 - Writing one clears flag; zero ignored
// R15 - Enabled idle interrupt requests immediately and continuously
// R16 - Sixteen-bit value register feeds fuse writes
// R17 - Sixteen-bit location register selects target memory
// R18 - Buffer clear fills ones, halts CPU seven cycles
// R19 - Debug port loads location, value, then command
// R20 - Command writes without key are ignored
// R21 - Interrupt held while enabled and flag set
// R22 - Unused bits read zero, writes ignored
module nvc_ctrl
#(
  parameter logic [15:0] EE_BASE    = 16'h1400,
  parameter logic [15:0] EE_SIZE    = 16'h0080,
  parameter logic [15:0] FL_BASE    = 16'h8000,
  parameter logic [15:0] BOOT_SIZE  = 16'h0200
)
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 dbg_access,
  input  wire logic                 exec_in_boot,
  input  wire logic                 eeprom_preserve_fuse,
  input  wire logic                 buf_wr,
  input  wire logic [15:0]          buf_wr_addr,
  input  wire logic                 buf_mixed,
  input  wire logic                 flash_done,
  input  wire logic                 eeprom_done,
  input  wire logic                 op_failed,
  input  wire logic                 mem_rd_boot,
  input  wire logic [15:0]          mem_rd_word,
  output logic [15:0]               mem_rd_gated,
  output logic                      boot_lock_active,
  output logic                      op_start,
  output logic [nvc_pkg::CMD_W-1:0] op_code,
  output logic                      op_on_flash,
  output logic                      op_on_eeprom,
  output logic [15:0]               op_location,
  output logic [15:0]               op_value,
  output logic                      buf_reset,
  output logic                      cpu_halt,
  output logic                      irq
);
  import nvc_pkg::*;

  typedef struct packed {
    logic              hready;
    logic [31:0]       hrdata;
    logic              rd_pend;
    logic              wr_pend;
    logic              wr_dbg;
    logic [5:0]        idx;
    logic [CMD_W-1:0]  cmd;
    logic [2:0]        key_cnt;
    logic              boot_lock;
    logic              boot_pend;
    logic              app_guard;
    logic              fault;
    logic              fl_busy;
    logic              ee_busy;
    logic              ee_halt;
    logic              irq_en;
    logic              irq_flag;
    logic              irq;
    logic [15:0]       value;
    logic [15:0]       location;
    logic              op_start;
    logic [CMD_W-1:0]  op_code;
    logic              op_fl;
    logic              op_ee;
    logic [2:0]        halt_cnt;
    logic              halt;
    logic              buf_reset;
    logic [15:0]       rd_gated;
  } nvc_state_t;

  nvc_state_t st_ff;
  nvc_state_t nxt_st;

  logic              addr_phase;
  logic              tgt_ee;
  logic              tgt_fl;
  logic              tgt_app;
  logic              any_busy;
  logic [CMD_W-1:0]  wr_cmd;
  logic              cmd_write;
  logic              key_write;

  assign addr_phase = hsel && htrans[1] && hready;
  assign tgt_ee     = (st_ff.location >= EE_BASE) && (st_ff.location < EE_BASE + EE_SIZE);
  assign tgt_fl     = (st_ff.location >= FL_BASE);
  assign tgt_app    = tgt_fl && (st_ff.location >= FL_BASE + BOOT_SIZE);
  assign any_busy   = st_ff.fl_busy || st_ff.ee_busy || (st_ff.halt_cnt != 3'h0);
  assign wr_cmd     = hwdata[CMD_W-1:0];
  assign cmd_write  = st_ff.wr_pend && (st_ff.idx == IDX_COMMAND);
  assign key_write  = st_ff.wr_pend && (st_ff.idx == IDX_KEY)
                      && (hwdata[7:0] == SELF_PROGRAM_KEY);

  // Read view of the register file; unused bits stay zero [R22]
  function automatic logic [31:0] read_reg(input nvc_state_t s, input logic [5:0] i);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (i)
      IDX_COMMAND:  r[CMD_W-1:0] = s.cmd;
      IDX_PROTECT:
      begin
        r[BIT_BOOT_LOCK] = s.boot_lock | s.boot_pend;
        r[BIT_APP_GUARD] = s.app_guard;
      end
      IDX_STATUS:
      begin
        r[BIT_FAULT]     = s.fault;     // [R9]
        r[BIT_EE_ACTIVE] = s.ee_busy;   // [R10]
        r[BIT_FL_ACTIVE] = s.fl_busy;   // [R11]
      end
      IDX_IRQ_EN:   r[BIT_EE_IDLE] = s.irq_en;
      IDX_IRQ_FLAG: r[BIT_EE_IDLE] = s.irq_flag;
      IDX_VALUE:    r[15:0] = s.value;
      IDX_LOCATION: r[15:0] = s.location;
      default:      r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.op_start  = 1'b0;
    nxt_st.buf_reset = 1'b0;
    nxt_st.wr_pend   = 1'b0;
    nxt_st.rd_pend   = 1'b0;
    nxt_st.hready    = 1'b1;

    // Bus address phase; a read waits one cycle so earlier writes are seen
    if (st_ff.rd_pend)
    begin
      nxt_st.hrdata = read_reg(st_ff, st_ff.idx);
    end
    if (addr_phase)
    begin
      nxt_st.idx     = haddr[7:2];
      nxt_st.wr_dbg  = dbg_access;
      nxt_st.wr_pend = hwrite;
      nxt_st.rd_pend = !hwrite;
      nxt_st.hready  = hwrite;
    end

    // Key window counts down one cycle at a time
    if (st_ff.key_cnt != 3'h0)
    begin
      nxt_st.key_cnt = st_ff.key_cnt - 3'h1;
    end
    if (key_write)
    begin
      nxt_st.key_cnt = KEY_WINDOW_CYCLES;
    end

    // Completion of array operations
    if (flash_done)
    begin
      nxt_st.fl_busy = 1'b0;                                          // [R11]
    end
    if (eeprom_done)
    begin
      nxt_st.ee_busy = 1'b0;                                          // [R10]
      nxt_st.ee_halt = 1'b0;
    end
    if ((flash_done || eeprom_done) && op_failed)
    begin
      nxt_st.fault = 1'b1;                                            // [R9]
    end
    if ((flash_done || eeprom_done) && !(nxt_st.fl_busy || nxt_st.ee_busy))
    begin
      nxt_st.cmd = CMD_NONE;
    end

    // Buffer clear stall
    if (st_ff.halt_cnt != 3'h0)
    begin
      nxt_st.halt_cnt = st_ff.halt_cnt - 3'h1;                        // [R18]
    end
    if (st_ff.halt_cnt == 3'h1)
    begin
      nxt_st.cmd = CMD_NONE;
    end

    // Register writes in the data phase
    if (st_ff.wr_pend)
    begin
      unique case (st_ff.idx)
        IDX_PROTECT:
        begin
          if (hwdata[BIT_APP_GUARD])
          begin
            nxt_st.app_guard = 1'b1;                                  // [R8]
          end
          if (hwdata[BIT_BOOT_LOCK] && exec_in_boot && !st_ff.boot_lock)
          begin
            nxt_st.boot_pend = 1'b1;                                  // [R6]
          end
        end
        IDX_IRQ_EN:
        begin
          nxt_st.irq_en = hwdata[BIT_EE_IDLE];                        // [R12]
        end
        IDX_VALUE:
        begin
          nxt_st.value = hwdata[15:0];                                // [R16]
        end
        IDX_LOCATION:
        begin
          nxt_st.location = hwdata[15:0];                             // [R17]
        end
        default:
        begin
        end
      endcase
    end

    // Command issue; without an open key window nothing changes [R20]
    if (cmd_write && (st_ff.key_cnt != 3'h0))
    begin
      nxt_st.key_cnt = 3'h0;
      nxt_st.op_code = wr_cmd;
      nxt_st.op_fl   = 1'b0;
      nxt_st.op_ee   = 1'b0;
      unique case (wr_cmd)                                            // [R1]
        CMD_NONE:
        begin
          nxt_st.cmd = CMD_NONE;
        end
        CMD_PAGE_PROG, CMD_PAGE_WIPE, CMD_WIPE_PROG:
        begin
          // Location selects the array [R17]
          if (any_busy || buf_mixed || !(tgt_ee || tgt_fl)
              || (tgt_app && st_ff.app_guard))                        // [R8]
          begin
            nxt_st.fault = 1'b1;                                      // [R9]
          end
          else
          begin
            nxt_st.fault    = 1'b0;
            nxt_st.cmd      = wr_cmd;
            nxt_st.op_start = 1'b1;
            nxt_st.op_ee    = tgt_ee;
            nxt_st.op_fl    = !tgt_ee;
            nxt_st.ee_busy  = tgt_ee;
            nxt_st.fl_busy  = !tgt_ee;
          end
        end
        CMD_BUF_RESET:
        begin
          // Taken even while an array is busy; the buffer is set to ones by the array side
          nxt_st.cmd       = wr_cmd;
          nxt_st.fault     = 1'b0;
          nxt_st.buf_reset = 1'b1;                                    // [R18]
          nxt_st.halt_cnt  = BUF_RESET_CYCLES;                        // [R18]
        end
        CMD_FULL_WIPE:
        begin
          if (any_busy)
          begin
            nxt_st.fault = 1'b1;
          end
          else
          begin
            nxt_st.fault    = 1'b0;
            nxt_st.cmd      = wr_cmd;
            nxt_st.op_start = 1'b1;
            nxt_st.op_fl    = 1'b1;
            nxt_st.fl_busy  = 1'b1;
            nxt_st.op_ee    = !eeprom_preserve_fuse;                  // [R3]
            nxt_st.ee_busy  = !eeprom_preserve_fuse;                  // [R3]
          end
        end
        CMD_EE_WIPE:
        begin
          if (any_busy)
          begin
            nxt_st.fault = 1'b1;
          end
          else
          begin
            nxt_st.fault    = 1'b0;
            nxt_st.cmd      = wr_cmd;
            nxt_st.op_start = 1'b1;
            nxt_st.op_ee    = 1'b1;
            nxt_st.ee_busy  = 1'b1;
            nxt_st.ee_halt  = 1'b1;
          end
        end
        CMD_CFG_PROG:
        begin
          // Processor attempts are refused and flagged [R4]
          if (any_busy || !st_ff.wr_dbg)
          begin
            nxt_st.fault = 1'b1;
          end
          else
          begin
            nxt_st.fault    = 1'b0;
            nxt_st.cmd      = wr_cmd;
            nxt_st.op_start = 1'b1;                                   // [R4]
            nxt_st.op_ee    = 1'b1;
            nxt_st.ee_busy  = 1'b1;
          end
        end
      endcase
    end

    // Array side updates the last touched location
    if (buf_wr)
    begin
      nxt_st.location = buf_wr_addr;                                  // [R17]
    end

    // Lock becomes active once boot code has been left [R7]
    if (st_ff.boot_pend && !exec_in_boot)
    begin
      nxt_st.boot_lock = 1'b1;
      nxt_st.boot_pend = 1'b0;
    end

    // Flag follows EEPROM idle; a set beats a same-cycle clear [R14] [R15]
    if (st_ff.wr_pend && (st_ff.idx == IDX_IRQ_FLAG) && hwdata[BIT_EE_IDLE])
    begin
      nxt_st.irq_flag = 1'b0;
    end
    if (!st_ff.ee_busy)
    begin
      nxt_st.irq_flag = 1'b1;                                         // [R15]
    end
    nxt_st.irq = st_ff.irq_en && st_ff.irq_flag;                      // [R21]

    // Locked boot reads return zero [R5]
    nxt_st.rd_gated = (st_ff.boot_lock && mem_rd_boot) ? RST_WORD : mem_rd_word;

    nxt_st.halt = nxt_st.fl_busy || nxt_st.ee_halt || (nxt_st.halt_cnt != 3'h0);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff        <= '0;
      st_ff.hready <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout        = st_ff.hready;
  assign hresp            = 1'b0 & st_ff.hready;
  assign hrdata           = st_ff.hrdata;
  assign mem_rd_gated     = st_ff.rd_gated;
  assign boot_lock_active = st_ff.boot_lock;
  assign op_start         = st_ff.op_start;
  assign op_code          = st_ff.op_code;
  assign op_on_flash      = st_ff.op_fl;
  assign op_on_eeprom     = st_ff.op_ee;
  assign op_location      = st_ff.location;
  assign op_value         = st_ff.value;
  assign buf_reset        = st_ff.buf_reset;
  assign cpu_halt         = st_ff.halt;
  assign irq              = st_ff.irq;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_buf_reset_issue;
    cmd_write && (st_ff.key_cnt != 3'h0) && (wr_cmd == CMD_BUF_RESET);
  endsequence

  sequence s_halt_seven;
    cpu_halt [*7] ##1 (st_ff.halt == (st_ff.fl_busy || st_ff.ee_halt));
  endsequence

  a_buf_reset_halt: assert property (s_buf_reset_issue |=> buf_reset ##0 s_halt_seven) // [R18]
    else $error("buffer clear halt length wrong");

  a_cmd_no_key: assert property (cmd_write && (st_ff.key_cnt == 3'h0) |=> !op_start
                                 && !buf_reset) // [R20]
    else $error("command taken without key");

  // Only a keyed attempt reaches the decoder; an unkeyed one is silently dropped
  a_cfg_cpu_refuse: assert property (cmd_write && (st_ff.key_cnt != 3'h0) && !st_ff.wr_dbg
                                     && (wr_cmd == CMD_CFG_PROG)
                                     |=> !op_start && st_ff.fault) // [R4]
    else $error("fuse write accepted from processor");

  a_wipe_preserve: assert property (op_start && (op_code == CMD_FULL_WIPE)
                                    |-> op_on_flash && (op_on_eeprom == !$past(eeprom_preserve_fuse))) // [R3]
    else $error("chip erase target wrong");

  a_lock_sticky: assert property ($fell(boot_lock_active) == 1'b0 && !$fell(st_ff.app_guard)) // [R6] [R8]
    else $error("lock or guard cleared without reset");

  a_lock_deferred: assert property ($rose(boot_lock_active) |-> !$past(exec_in_boot)) // [R7]
    else $error("boot lock took effect inside boot");

  a_boot_zero: assert property (boot_lock_active && mem_rd_boot |=> mem_rd_gated == 16'h0000) // [R5]
    else $error("locked boot read not zero");

  a_irq_level: assert property (st_ff.irq_en && st_ff.irq_flag |=> irq) // [R21]
    else $error("interrupt not raised");

  // Enable must survive the flag's set cycle, else a disable write trips this
  a_idle_request: assert property (st_ff.irq_en && !st_ff.ee_busy ##1 st_ff.irq_en
                                   |=> irq) // [R15]
    else $error("idle interrupt not continuous");

  a_ee_active: assert property (op_start && op_on_eeprom && !eeprom_done
                                |=> st_ff.ee_busy) // [R10]
    else $error("eeprom active bit missing");

  a_fl_active: assert property (op_start && op_on_flash && !flash_done |=> st_ff.fl_busy) // [R11]
    else $error("flash active bit missing");

  a_guard_fault: assert property (cmd_write && (st_ff.key_cnt != 3'h0) && st_ff.app_guard
                                  && tgt_app && (wr_cmd == CMD_PAGE_PROG)
                                  |=> st_ff.fault && !op_start) // [R8] [R9]
    else $error("guarded write not refused");

endmodule

//--- tb/nvc_mem_model.sv
// Purpose: Behavioural flash and EEPROM arrays behind the controller
// Assumes: Every started operation except buffer clear finishes after DONE_LAT cycles
// Notes:   Fails an operation only when the bench raises fail_next
module nvc_mem_model
  import nvc_pkg::*;
#(
  parameter int DONE_LAT = 12
)
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 op_start,
  input  wire logic [nvc_pkg::CMD_W-1:0] op_code,
  input  wire logic                 fail_next,
  output logic                      flash_done,
  output logic                      eeprom_done,
  output logic                      op_failed
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Both arrays report done; the controller ignores the idle one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt         <= 0;
      flash_done  <= 1'b0;
      eeprom_done <= 1'b0;
      op_failed   <= 1'b0;
    end
    else
    begin
      flash_done  <= 1'b0;
      eeprom_done <= 1'b0;
      op_failed   <= 1'b0;
      if (op_start && op_code != CMD_BUF_RESET)
        cnt <= DONE_LAT;
      else if (cnt == 1)
      begin
        flash_done  <= 1'b1;
        eeprom_done <= 1'b1;
        op_failed   <= fail_next;
        cnt         <= 0;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule

//--- tb/test_nvc_ctrl.sv
// Purpose: Self-checking bench for the memory command controller
// Assumes: One AHB-Lite master, hready looped back from hreadyout
// Notes:   Bus waits poll hreadyout under a bound, never a fixed count
module test_nvc_ctrl
  import nvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hreadyout, hresp, flash_done, eeprom_done, op_failed;
  logic        hresetn = 0, hsel = 0, hwrite = 0, dbg_access = 0, exec_in_boot = 0;
  logic        eeprom_preserve_fuse = 0, buf_wr = 0, buf_mixed = 0, mem_rd_boot = 0;
  logic        fail_next = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [15:0] buf_wr_addr = 0, mem_rd_word = 0;
  logic [31:0] hrdata, rv;
  logic [15:0] mem_rd_gated, op_location, op_value, last_val;
  logic        boot_lock_active, op_start, op_on_flash, op_on_eeprom, buf_reset, cpu_halt, irq;
  logic        last_fl, last_ee;
  logic [2:0]  op_code, last_code;
  int          miscompares, n_checks, starts, halts, resets;

  nvc_ctrl nvc_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dbg_access, .exec_in_boot,
    .eeprom_preserve_fuse, .buf_wr, .buf_wr_addr, .buf_mixed, .flash_done, .eeprom_done,
    .op_failed, .mem_rd_boot, .mem_rd_word, .mem_rd_gated, .boot_lock_active, .op_start,
    .op_code, .op_on_flash, .op_on_eeprom, .op_location, .op_value, .buf_reset, .cpu_halt,
    .irq);
  nvc_mem_model nvc_mem_model_inst (.hclk, .hresetn, .op_start, .op_code, .fail_next,
    .flash_done, .eeprom_done, .op_failed);

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    if (op_start === 1'b1)
    begin
      starts++;
      last_code = op_code;
      last_fl = op_on_flash;
      last_ee = op_on_eeprom;
      last_val = op_value;
    end
    if (cpu_halt === 1'b1)
      halts++;
    if (buf_reset === 1'b1)
      resets++;
  end

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      close_out();
    end
  endtask

  // Called right after a rising edge; returns on the data-phase edge
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rv = hrdata;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rv, exp);
  endtask

  task automatic issue(input logic [2:0] c);
    xfer(1'b1, IDX_KEY, {24'h000000, SELF_PROGRAM_KEY});
    xfer(1'b1, IDX_COMMAND, {29'h0, c});
    repeat (2) @(posedge hclk);
  endtask

  task automatic wait_idle;
    int n;
    for (n = 0; n < 60; n++)
    begin
      xfer(1'b0, IDX_STATUS, 32'h0);
      if (rv[1:0] === 2'b00)
        break;
    end
    if (n == 60)
    begin
      miscompares++;
      close_out();
    end
  endtask

  task automatic t_reset;
    rd_chk(IDX_COMMAND, 32'h0);
    rd_chk(IDX_PROTECT, 32'h0);
    rd_chk(IDX_STATUS, 32'h0);
    rd_chk(IDX_IRQ_EN, 32'h0);
    rd_chk(IDX_IRQ_FLAG, 32'h1);
    rd_chk(IDX_VALUE, 32'h0);
    rd_chk(IDX_LOCATION, 32'h0);
    rd_chk(6'h05, 32'h0);
    rd_chk(6'h0B, 32'h0);
  endtask

  task automatic t_key;
    xfer(1'b1, IDX_LOCATION, 32'h1400);
    xfer(1'b1, IDX_COMMAND, {29'h0, CMD_PAGE_WIPE});
    repeat (2) @(posedge hclk);
    chk(starts, 0);
    // Key gone stale before the command lands
    xfer(1'b1, IDX_KEY, {24'h000000, SELF_PROGRAM_KEY});
    repeat (6) @(posedge hclk);
    xfer(1'b1, IDX_COMMAND, {29'h0, CMD_PAGE_WIPE});
    repeat (2) @(posedge hclk);
    chk(starts, 0);
    chk(hresp, 1'b0);
    rd_chk(IDX_COMMAND, 32'h0);
  endtask

  task automatic t_codes;
    int s;
    resets = 0;
    for (int c = 1; c < 7; c++)
    begin
      s = starts;
      halts = 0;
      issue(c[2:0]);
      // Buffer clear is a local stall only: no array start, just the pulse
      if (c == 4)
      begin
        repeat (10) @(posedge hclk);
        chk(starts, s);
        chk(op_code, 3'h4);
        chk(halts, 7);
        chk(resets, 1);
      end
      else
      begin
        chk(starts, s + 1);
        chk(last_code, c);
      end
      if (c != 4 && c != 5)
      begin
        rd_chk(IDX_STATUS, 32'h2);
        rd_chk(IDX_COMMAND, c);
      end
      if (c == 5)
        chk(last_ee, 1'b1);
      wait_idle();
    end
    eeprom_preserve_fuse <= 1'b1;
    issue(CMD_FULL_WIPE);
    chk(last_ee, 1'b0);
    wait_idle();
    eeprom_preserve_fuse <= 1'b0;
  endtask

  task automatic t_flash;
    int s;
    xfer(1'b1, IDX_LOCATION, 32'h8400);
    buf_mixed <= 1'b1;
    s = starts;
    issue(CMD_PAGE_PROG);
    chk(starts, s);
    rd_chk(IDX_STATUS, 32'h4);
    buf_mixed <= 1'b0;
    fail_next <= 1'b1;
    issue(CMD_PAGE_PROG);
    chk(last_fl, 1'b1);
    rd_chk(IDX_STATUS, 32'h1);
    wait_idle();
    rd_chk(IDX_STATUS, 32'h4);
    fail_next <= 1'b0;
  endtask

  task automatic t_fuse;
    int s;
    xfer(1'b1, IDX_VALUE, 32'hFFFFA55A);
    rd_chk(IDX_VALUE, 32'h0000A55A);
    s = starts;
    issue(CMD_CFG_PROG);
    chk(starts, s);
    dbg_access <= 1'b1;
    xfer(1'b1, IDX_LOCATION, 32'h1280);
    xfer(1'b1, IDX_VALUE, 32'h5AA5);
    issue(CMD_CFG_PROG);
    dbg_access <= 1'b0;
    chk(starts, s + 1);
    chk(last_val, 16'h5AA5);
    rd_chk(IDX_STATUS, 32'h2);
    wait_idle();
  endtask

  task automatic t_loc;
    buf_wr      <= 1'b1;
    buf_wr_addr <= 16'h1410;
    @(posedge hclk);
    buf_wr <= 1'b0;
    @(posedge hclk);
    rd_chk(IDX_LOCATION, 32'h1410);
    chk(op_location, 16'h1410);
  endtask

  task automatic t_irq;
    chk(irq, 1'b0);
    xfer(1'b1, IDX_IRQ_EN, 32'hFF);
    rd_chk(IDX_IRQ_EN, 32'h1);
    chk(irq, 1'b1);
    xfer(1'b1, IDX_IRQ_FLAG, 32'h0);
    rd_chk(IDX_IRQ_FLAG, 32'h1);
    issue(CMD_PAGE_WIPE);
    xfer(1'b1, IDX_IRQ_FLAG, 32'h1);
    rd_chk(IDX_IRQ_FLAG, 32'h0);
    chk(irq, 1'b0);
    wait_idle();
    rd_chk(IDX_IRQ_FLAG, 32'h1);
    chk(irq, 1'b1);
    xfer(1'b1, IDX_IRQ_EN, 32'h0);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
  endtask

  task automatic t_guard;
    int s;
    xfer(1'b1, IDX_PROTECT, 32'h1);
    xfer(1'b1, IDX_PROTECT, 32'h0);
    rd_chk(IDX_PROTECT, 32'h1);
    xfer(1'b1, IDX_LOCATION, 32'h8400);
    s = starts;
    issue(CMD_PAGE_PROG);
    chk(starts, s);
    rd_chk(IDX_STATUS, 32'h4);
  endtask

  task automatic t_boot;
    mem_rd_word <= 16'hBEEF;
    mem_rd_boot <= 1'b1;
    xfer(1'b1, IDX_PROTECT, 32'h2);
    rd_chk(IDX_PROTECT, 32'h1);
    exec_in_boot <= 1'b1;
    xfer(1'b1, IDX_PROTECT, 32'h2);
    rd_chk(IDX_PROTECT, 32'h3);
    chk(boot_lock_active, 1'b0);
    chk(mem_rd_gated, 16'hBEEF);
    exec_in_boot <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(boot_lock_active, 1'b1);
    chk(mem_rd_gated, 16'h0);
    mem_rd_boot <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(mem_rd_gated, 16'hBEEF);
    xfer(1'b1, IDX_PROTECT, 32'h0);
    rd_chk(IDX_PROTECT, 32'h3);
  endtask

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_key();
    t_codes();
    t_flash();
    t_fuse();
    t_loc();
    t_irq();
    t_guard();
    t_boot();
    close_out();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    close_out();
  end
endmodule
